// File: logic/rtwr_pkg.sv
package rtwr_pkg;
  // register byte addresses
  localparam logic [31:0] RTWR_IF_TRIM_ONE = 32'h500101E0;
  localparam logic [31:0] RTWR_IF_TRIM_TWO = 32'h500101E4;
  localparam logic [31:0] RTWR_WAKE_CONTROL = 32'h50010200;
  localparam logic [31:0] RTWR_BACKOFF_TIMEOUT = 32'h50010204;
  localparam logic [31:0] RTWR_IRQ_STATUS = 32'h50010210;
  localparam logic [31:0] RTWR_IRQ_MASK = 32'h50010214;
  // if_trim_one fields
  localparam int RTWR_IF_AMP_CUR_POS = 0;
  localparam int RTWR_LIM_CUR_POS = 1;
  localparam int RTWR_BPF_CUR_POS = 2;
  localparam int RTWR_OSC_BUF_POS = 4;
  localparam int RTWR_RX_LO_BOOST_POS = 6;
  localparam int RTWR_TX_LO_BOOST_POS = 7;
  localparam int RTWR_RX_LO_BUF_POS = 8;
  localparam int RTWR_TX_LO_BUF_POS = 10;
  localparam int RTWR_LNA_VREF_POS = 12;
  localparam int RTWR_LO_VREF_POS = 13;
  localparam int RTWR_QCHG_OFF_POS = 14;
  localparam int RTWR_RSV_TRIM_POS = 15;
  // if_trim_two fields
  localparam int RTWR_ROUTE_POS = 0;
  localparam int RTWR_PROBE_POS = 16;
  localparam int RTWR_STAGE_POS = 20;
  localparam int RTWR_RSV_FILT_POS = 21;
  // wake_control fields
  localparam int RTWR_TIMER_EN_POS = 0;
  localparam int RTWR_TX_EN_POS = 1;
  localparam int RTWR_RX_EN_POS = 2;
  localparam int RTWR_LOOP_POS = 8;
  localparam int RTWR_COND_POS = 12;
  localparam int RTWR_FLAG_POS = 16;
  // interrupt status bits
  localparam int RTWR_EV_TIMER = 0;
  localparam int RTWR_EV_RX_WAKE = 1;
  localparam int RTWR_EV_BACKOFF = 2;
  localparam int RTWR_EV_N = 3;
  // reset values
  localparam logic [15:0] RTWR_TRIM_ONE_RST = 16'h0000;
  localparam logic [15:0] RTWR_TIMEOUT_RST = 16'h0000;
  // wake conditions
  localparam logic [1:0] RTWR_COND_CARRIER = 2'h0;
  localparam logic [1:0] RTWR_COND_SYNC = 2'h1;
  localparam logic [1:0] RTWR_COND_BEACON = 2'h2;
  localparam logic [1:0] RTWR_COND_CRC = 2'h3;
  // back-off unit time and clock
  localparam int RTWR_UNIT_US = 320;
  localparam int RTWR_CLK_MHZ = 100;
  localparam int RTWR_UNIT_CYCLES = RTWR_UNIT_US * RTWR_CLK_MHZ;
  // axi responses
  localparam logic [1:0] RTWR_RESP_OKAY = 2'h0;
  localparam logic [1:0] RTWR_RESP_SLVERR = 2'h2;
  // bus channel states
  typedef enum logic [1:0] {
    RTWR_CH_IDLE = 2'b01,
    RTWR_CH_RESP = 2'b10
  } rtwr_ch_t;
endpackage

// File: logic/rtwr_backoff_timer.sv
`timescale 1ns/10ps
module rtwr_backoff_timer #(
  parameter int UNIT_CYCLES = 32000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  input wire logic [15:0] timeout,
  // status
  output logic busy,
  output logic expire
);
  logic [31:0] sub_cnt;
  logic [15:0] unit_cnt;
  logic unit_end;

  assign unit_end = sub_cnt == 32'(UNIT_CYCLES - 1);

  // time-out is (timeout + 1) units long
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      sub_cnt <= '0;
      unit_cnt <= '0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (start) begin // restart wins over a running count
        busy <= 1'b1;
        sub_cnt <= '0;
        unit_cnt <= timeout;
      end else if (busy) begin
        sub_cnt <= unit_end ? '0 : sub_cnt + 32'h1;
        if (unit_end) begin
          if (unit_cnt == 16'h0) begin
            busy <= 1'b0;
            expire <= 1'b1;
          end else begin
            unit_cnt <= unit_cnt - 16'h1;
          end
        end
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_expire_after_busy: assert property (expire |-> $past(busy) && !busy)
    else $error("expire without a running count");
  a_start_busy: assert property (start |=> busy && !expire)
    else $error("start did not arm the timer");
endmodule

// File: logic/rtwr_regs.sv
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module rtwr_regs #(
  parameter int UNIT_CYCLES = rtwr_pkg::RTWR_UNIT_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // radio events
  input wire logic carrier_detect,
  input wire logic sync_word_detect,
  input wire logic beacon_detect,
  input wire logic crc_pass,
  input wire logic wake_timer_expire,
  input wire logic rx_backoff_start,
  input wire logic [15:0] backoff_difference,
  // wake controls
  output logic rx_wake_en,
  output logic tx_wake_en,
  output logic timer_wake_en,
  output logic [3:0] tx_wake_loop_time,
  output logic rx_wake_trigger,
  output logic rx_backoff_timeout,
  // analog trims
  output logic [15:0] trim_word,
  output logic [10:0] osc_buffer_ua,
  output logic [9:0] limiter_ua,
  output logic limiter_quick_charge_en,
  // antenna and probe
  output logic shared_antenna_port_rx_en,
  output logic shared_antenna_port_tx_en,
  output logic tx_only_port_en,
  output logic [2:0] probe_node,
  output logic probe_en,
  // interrupt
  output logic irq
);
  import rtwr_pkg::*;

  rtwr_ch_t wr_state;
  rtwr_ch_t rd_state;
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [15:0] trim_two;
  logic [1:0] wake_condition_sel;
  logic wake_timer_flag;
  logic [15:0] backoff_rx_timeout;
  logic [RTWR_EV_N-1:0] irq_status;
  logic [RTWR_EV_N-1:0] irq_mask;
  logic [RTWR_EV_N-1:0] events;
  logic flag_clear;
  logic next_trigger;
  logic timer_busy;
  logic timer_expire;
  logic rd_trim;
  logic [31:0] trim_two_merged;

  // decode an address to a known register
  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = a == RTWR_IF_TRIM_ONE || a == RTWR_IF_TRIM_TWO || a == RTWR_WAKE_CONTROL ||
      a == RTWR_BACKOFF_TIMEOUT || a == RTWR_IRQ_STATUS || a == RTWR_IRQ_MASK;
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // handshake outputs straight from channel state
  assign s_axi_awready = wr_state == RTWR_CH_IDLE && !aw_held;
  assign s_axi_wready = wr_state == RTWR_CH_IDLE && !w_held;
  assign s_axi_arready = rd_state == RTWR_CH_IDLE;
  assign wr_fire = wr_state == RTWR_CH_IDLE && aw_held && w_held;

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= RTWR_CH_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RTWR_RESP_OKAY;
    end else begin
      case (wr_state)
        RTWR_CH_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
          end
          if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_hit(aw_addr) ? RTWR_RESP_OKAY : RTWR_RESP_SLVERR;
            wr_state <= RTWR_CH_RESP;
          end
        end
        RTWR_CH_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state <= RTWR_CH_IDLE;
          end
        end
        default: wr_state <= RTWR_CH_IDLE;
      endcase
    end
  end

  // trim_two keeps word bits 21:16 in [15:10] and the route bit in [0]
  assign trim_two_merged = merge({10'h000, trim_two[15:10], 15'h0000, trim_two[0]}, w_data, w_strb);

  // trim and routing registers, write only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_word <= RTWR_TRIM_ONE_RST;
      trim_two <= '0;
    end else if (wr_fire) begin
      if (aw_addr == RTWR_IF_TRIM_ONE) begin
        trim_word <= 16'(merge({16'h0000, trim_word}, w_data, w_strb));
      end
      if (aw_addr == RTWR_IF_TRIM_TWO) begin
        trim_two <= {trim_two_merged[21:16], 9'h000, trim_two_merged[RTWR_ROUTE_POS]};
      end
    end
  end

  // wake control, time-out value and interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_wake_en <= 1'b0;
      tx_wake_en <= 1'b0;
      timer_wake_en <= 1'b0;
      tx_wake_loop_time <= '0;
      wake_condition_sel <= RTWR_COND_CARRIER;
      backoff_rx_timeout <= RTWR_TIMEOUT_RST;
      irq_mask <= '0;
    end else if (wr_fire) begin
      if (aw_addr == RTWR_WAKE_CONTROL && w_strb[0]) begin
        rx_wake_en <= w_data[RTWR_RX_EN_POS];
        tx_wake_en <= w_data[RTWR_TX_EN_POS];
        timer_wake_en <= w_data[RTWR_TIMER_EN_POS];
      end
      if (aw_addr == RTWR_WAKE_CONTROL && w_strb[1]) begin
        tx_wake_loop_time <= w_data[RTWR_LOOP_POS +: 4];
        wake_condition_sel <= w_data[RTWR_COND_POS +: 2];
      end
      if (aw_addr == RTWR_BACKOFF_TIMEOUT) begin
        backoff_rx_timeout <= 16'(merge({16'h0000, backoff_rx_timeout}, w_data, w_strb));
      end
      if (aw_addr == RTWR_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[RTWR_EV_N-1:0];
      end
    end
  end

  assign flag_clear = wr_fire && aw_addr == RTWR_WAKE_CONTROL && w_strb[2] && w_data[RTWR_FLAG_POS];

  // wake-timer flag; a new expiry beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_timer_flag <= 1'b0;
    end else if (wake_timer_expire) begin
      wake_timer_flag <= 1'b1;
    end else if (flag_clear) begin
      wake_timer_flag <= 1'b0;
    end
  end

  // wake condition select picks the trigger
  always_comb begin
    case (wake_condition_sel)
      RTWR_COND_CARRIER: next_trigger = carrier_detect;
      RTWR_COND_SYNC: next_trigger = sync_word_detect;
      RTWR_COND_BEACON: next_trigger = beacon_detect;
      RTWR_COND_CRC: next_trigger = crc_pass;
      default: next_trigger = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_wake_trigger <= 1'b0;
    end else begin
      rx_wake_trigger <= rx_wake_en && next_trigger;
    end
  end

  // back-off time-out counter
  rtwr_backoff_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(rx_backoff_start),
    .timeout(backoff_rx_timeout),
    .busy(timer_busy),
    .expire(timer_expire)
  );
  assign rx_backoff_timeout = timer_expire;

  // analog decodes, registered so the pins never glitch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_buffer_ua <= 11'h258;
      limiter_ua <= 10'h12C;
      limiter_quick_charge_en <= 1'b1;
      shared_antenna_port_rx_en <= 1'b1;
      shared_antenna_port_tx_en <= 1'b1;
      tx_only_port_en <= 1'b0;
      probe_node <= '0;
      probe_en <= 1'b0;
    end else begin
      osc_buffer_ua <= 11'(600 + 200 * trim_word[RTWR_OSC_BUF_POS +: 2]);
      limiter_ua <= trim_word[RTWR_LIM_CUR_POS] ? 10'h258 : 10'h12C;
      limiter_quick_charge_en <= !trim_word[RTWR_QCHG_OFF_POS];
      shared_antenna_port_rx_en <= 1'b1;
      shared_antenna_port_tx_en <= !trim_two[RTWR_ROUTE_POS];
      tx_only_port_en <= trim_two[RTWR_ROUTE_POS];
      probe_en <= trim_two[RTWR_PROBE_POS-6 +: 4] != 4'h0 || trim_two[RTWR_STAGE_POS-6];
      if (trim_two[RTWR_PROBE_POS-6 +: 2] == 2'h0) begin
        probe_node <= 3'h0;
      end else if (trim_two[RTWR_PROBE_POS-6 +: 2] == 2'h1) begin
        probe_node <= 3'h1;
      end else if (!trim_two[RTWR_STAGE_POS-6]) begin
        probe_node <= {2'h1, trim_two[RTWR_PROBE_POS-6]};
      end else begin
        probe_node <= {1'b1, trim_two[RTWR_PROBE_POS-3], trim_two[RTWR_PROBE_POS-6]};
      end
    end
  end

  // interrupt status, write one to clear, set wins
  assign events = {timer_expire, rx_wake_trigger, wake_timer_expire};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < RTWR_EV_N; i++) begin
        if (events[i]) begin
          irq_status[i] <= 1'b1;
        end else if (wr_fire && aw_addr == RTWR_IRQ_STATUS && w_strb[0] && w_data[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end
  assign irq = |(irq_status & irq_mask);

  // read channel, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RTWR_CH_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RTWR_RESP_OKAY;
      rd_trim <= 1'b0;
    end else begin
      case (rd_state)
        RTWR_CH_IDLE: begin
          if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_hit(s_axi_araddr) ? RTWR_RESP_OKAY : RTWR_RESP_SLVERR;
            rd_trim <= s_axi_araddr == RTWR_IF_TRIM_ONE || s_axi_araddr == RTWR_IF_TRIM_TWO;
            rd_state <= RTWR_CH_RESP;
            case (s_axi_araddr)
              RTWR_WAKE_CONTROL: s_axi_rdata <= 32'({wake_timer_flag, 13'h0000, rx_wake_en, tx_wake_en, 1'b0});
              RTWR_BACKOFF_TIMEOUT: s_axi_rdata <= {16'h0000, backoff_difference};
              RTWR_IRQ_STATUS: s_axi_rdata <= 32'(irq_status);
              RTWR_IRQ_MASK: s_axi_rdata <= 32'(irq_mask);
              default: s_axi_rdata <= '0;
            endcase
          end
        end
        RTWR_CH_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state <= RTWR_CH_IDLE;
          end
        end
        default: rd_state <= RTWR_CH_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_clear_write;
    flag_clear && !wake_timer_expire;
  endsequence

  a_flag_set: assert property (wake_timer_expire |=> wake_timer_flag)
    else $error("wake-timer flag not set on expiry");
  a_flag_clear: assert property (s_clear_write |=> !wake_timer_flag)
    else $error("wake-timer flag not cleared");
  a_rx_wake_gate: assert property (!rx_wake_en |=> !rx_wake_trigger)
    else $error("rx wake trigger while disabled");
  a_rx_wake_crc: assert property (rx_wake_en && wake_condition_sel == RTWR_COND_CRC && crc_pass
                                  |=> rx_wake_trigger)
    else $error("crc pass did not trigger");
  a_trim_read_zero: assert property (s_axi_rvalid && rd_trim |-> s_axi_rdata == 32'h0)
    else $error("write-only register read nonzero");
  a_diff_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == RTWR_BACKOFF_TIMEOUT
                                |=> s_axi_rdata[15:0] == $past(backoff_difference))
    else $error("back-off difference misread");
  a_route_split: assert property (trim_two[RTWR_ROUTE_POS] |=> tx_only_port_en && !shared_antenna_port_tx_en)
    else $error("split route not applied");
  a_osc_decode: assert property (trim_word[RTWR_OSC_BUF_POS +: 2] == 2'h3 |=> osc_buffer_ua == 11'h4B0)
    else $error("oscillator buffer current misdecoded");
  a_quick_charge: assert property (trim_word[RTWR_QCHG_OFF_POS] |=> !limiter_quick_charge_en)
    else $error("quick charge not disabled");
  a_wr_response: assert property (wr_fire |=> s_axi_bvalid)
    else $error("write response missing");
  a_timeout_idle: assert property (rx_backoff_timeout |-> !timer_busy)
    else $error("time-out pulse while count still running");
endmodule

// File: verification/rtwr_regs_bench.sv
`timescale 1ns/10ps
module rtwr_regs_bench;
  import rtwr_pkg::*;
  // short back-off unit keeps the time-out runs brief
  localparam int UNIT = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] ev = 4'h0;
  logic expire = 1'b0;
  logic bstart = 1'b0;
  logic [15:0] bdiff = 16'h0000;
  logic awready, wready, bvalid, arready, rvalid, rx_wake_en, tx_wake_en, timer_wake_en;
  logic rx_wake_trigger, rx_backoff_timeout, limiter_quick_charge_en, irq, probe_en;
  logic shared_antenna_port_rx_en, shared_antenna_port_tx_en, tx_only_port_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] tx_wake_loop_time;
  logic [15:0] trim_word;
  logic [10:0] osc_buffer_ua;
  logic [9:0] limiter_ua;
  logic [2:0] probe_node;
  int err_count = 0;
  int checks = 0;

  rtwr_regs #(.UNIT_CYCLES(UNIT)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .carrier_detect(ev[0]), .sync_word_detect(ev[1]), .beacon_detect(ev[2]), .crc_pass(ev[3]),
    .wake_timer_expire(expire), .rx_backoff_start(bstart), .backoff_difference(bdiff),
    .rx_wake_en(rx_wake_en), .tx_wake_en(tx_wake_en), .timer_wake_en(timer_wake_en),
    .tx_wake_loop_time(tx_wake_loop_time), .rx_wake_trigger(rx_wake_trigger),
    .rx_backoff_timeout(rx_backoff_timeout), .trim_word(trim_word), .osc_buffer_ua(osc_buffer_ua),
    .limiter_ua(limiter_ua), .limiter_quick_charge_en(limiter_quick_charge_en),
    .shared_antenna_port_rx_en(shared_antenna_port_rx_en),
    .shared_antenna_port_tx_en(shared_antenna_port_tx_en), .tx_only_port_en(tx_only_port_en),
    .probe_node(probe_node), .probe_en(probe_en), .irq(irq)
  );

  // 100 mhz clock
  always #5 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  // handshake seen mid-cycle, released just after the edge that took it
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, hb;
    int n;
    n = 0;
    hb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb && n < 50) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      hb = bvalid;
      if (hb) chk("bresp", 32'(er), 32'(bresp));
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!hb) chk("bvalid", 32'h1, 32'h0);
    // let the registered decodes settle before callers look
    @(negedge aclk);
  endtask

  task automatic axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, hr;
    int n;
    n = 0;
    hr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr && n < 50) begin
      @(negedge aclk);
      ta = arvalid && arready;
      hr = rvalid;
      if (hr) chk("rdata", ed, rdata);
      if (hr) chk("rresp", 32'(er), 32'(rresp));
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!hr) chk("rvalid", 32'h1, 32'h0);
    @(negedge aclk);
  endtask

  task automatic ev_pulse(input logic [3:0] v, input logic exp);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= 4'h0;
    @(negedge aclk);
    chk("trigger", 32'(exp), 32'(rx_wake_trigger));
    @(posedge aclk);
    @(negedge aclk);
    chk("trigger_len", 32'h0, 32'(rx_wake_trigger));
  endtask

  task automatic t_reset;
    chk("osc_ua", 32'h258, 32'(osc_buffer_ua));
    chk("lim_ua", 32'h12C, 32'(limiter_ua));
    chk("qc_en", 32'h1, 32'(limiter_quick_charge_en));
    chk("irq", 32'h0, 32'(irq));
    axr(RTWR_WAKE_CONTROL, 32'h0, RTWR_RESP_OKAY);
    axr(RTWR_IRQ_MASK, 32'h0, RTWR_RESP_OKAY);
    axr(32'h50010208, 32'h0, RTWR_RESP_SLVERR);
    axw(32'h50010208, 32'hFFFFFFFF, RTWR_RESP_SLVERR);
    axr(RTWR_WAKE_CONTROL, 32'h0, RTWR_RESP_OKAY);
    done("reset");
  endtask

  task automatic t_trim;
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      d = 32'((i << 4) | (i << 2) | ((i & 1) << 1) | ((i >> 1) << 14) | 32'h8000);
      axw(RTWR_IF_TRIM_ONE, d, RTWR_RESP_OKAY);
      chk("trim_word", d & 32'hFFFF, 32'(trim_word));
      chk("osc_ua", 32'(600 + 200 * i), 32'(osc_buffer_ua));
      chk("lim_ua", (i & 1) ? 32'h258 : 32'h12C, 32'(limiter_ua));
      chk("qc_en", 32'((i >> 1) == 0), 32'(limiter_quick_charge_en));
      axr(RTWR_IF_TRIM_ONE, 32'h0, RTWR_RESP_OKAY);
    end
    done("trim");
  endtask

  task automatic t_probe;
    logic [31:0] d, node;
    for (int i = 0; i < 16; i++) begin
      d = 32'(((i >> 3) << 20) | (((i >> 2) & 1) << 19) | ((i & 3) << 16) | (i & 1));
      if ((i & 2) == 0) node = 32'(i & 1);
      else if ((i >> 3) == 0) node = 32'(2 + (i & 1));
      else node = 32'(((i & 4) != 0 ? 6 : 4) + (i & 1));
      axw(RTWR_IF_TRIM_TWO, d, RTWR_RESP_OKAY);
      chk("probe_node", node, 32'(probe_node));
      chk("probe_en", 32'(i != 0), 32'(probe_en));
      chk("shared_tx", 32'((i & 1) == 0), 32'(shared_antenna_port_tx_en));
      chk("tx_only", 32'(i & 1), 32'(tx_only_port_en));
      chk("shared_rx", 32'h1, 32'(shared_antenna_port_rx_en));
    end
    axr(RTWR_IF_TRIM_TWO, 32'h0, RTWR_RESP_OKAY);
    done("probe");
  endtask

  task automatic t_wake;
    for (int c = 0; c < 4; c++) begin
      axw(RTWR_WAKE_CONTROL, 32'((c << 12) | 32'h0F07), RTWR_RESP_OKAY);
      chk("enables", 32'h7, 32'({rx_wake_en, tx_wake_en, timer_wake_en}));
      chk("loop", 32'hF, 32'(tx_wake_loop_time));
      axr(RTWR_WAKE_CONTROL, 32'h6, RTWR_RESP_OKAY);
      ev_pulse(4'(1 << ((c + 1) % 4)), 1'b0);
      ev_pulse(4'(1 << c), 1'b1);
    end
    // receive wake off must silence the selected trigger
    axw(RTWR_WAKE_CONTROL, 32'h3003, RTWR_RESP_OKAY);
    ev_pulse(4'h8, 1'b0);
    done("wake");
  endtask

  task automatic t_flag;
    axw(RTWR_IRQ_STATUS, 32'h7, RTWR_RESP_OKAY);
    axw(RTWR_IRQ_MASK, 32'h1, RTWR_RESP_OKAY);
    @(posedge aclk);
    expire <= 1'b1;
    @(posedge aclk);
    expire <= 1'b0;
    axr(RTWR_WAKE_CONTROL, 32'h10002, RTWR_RESP_OKAY);
    chk("irq", 32'h1, 32'(irq));
    axw(RTWR_IRQ_MASK, 32'h0, RTWR_RESP_OKAY);
    chk("irq_masked", 32'h0, 32'(irq));
    axw(RTWR_IRQ_MASK, 32'h1, RTWR_RESP_OKAY);
    axw(RTWR_WAKE_CONTROL, 32'h10000, RTWR_RESP_OKAY);
    axr(RTWR_WAKE_CONTROL, 32'h0, RTWR_RESP_OKAY);
    axr(RTWR_IRQ_STATUS, 32'h1, RTWR_RESP_OKAY);
    chk("irq_kept", 32'h1, 32'(irq));
    axw(RTWR_IRQ_STATUS, 32'h1, RTWR_RESP_OKAY);
    chk("irq_clear", 32'h0, 32'(irq));
    axr(RTWR_IRQ_STATUS, 32'h0, RTWR_RESP_OKAY);
    done("flag");
  endtask

  task automatic t_backoff;
    int n;
    bdiff <= 16'hA5C3;
    axr(RTWR_BACKOFF_TIMEOUT, 32'h0000A5C3, RTWR_RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      axw(RTWR_BACKOFF_TIMEOUT, 32'(2 * k), RTWR_RESP_OKAY);
      @(posedge aclk);
      bstart <= 1'b1;
      @(posedge aclk);
      bstart <= 1'b0;
      n = 0;
      while (n < 100) begin
        @(negedge aclk);
        if (rx_backoff_timeout) break;
        n++;
        @(posedge aclk);
      end
      chk("timeout_span", 32'h1, 32'(n == (2 * k + 1) * UNIT || n == (2 * k + 1) * UNIT + 1));
      @(posedge aclk);
      @(negedge aclk);
      chk("timeout_len", 32'h0, 32'(rx_backoff_timeout));
    end
    axr(RTWR_IRQ_STATUS, 32'h4, RTWR_RESP_OKAY);
    chk("irq_unmasked_only", 32'h0, 32'(irq));
    done("backoff");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_trim();
    t_probe();
    t_wake();
    t_flag();
    t_backoff();
    conclude();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200us;
    err_count++;
    conclude();
  end
endmodule
